// ===== osrc_dev.sv
// Purpose: Output alignment, reset modes and driver setup of the device
// Assumes: ref_clk_i is the channel divider input clock
// Notes:   Long waits are parameters so simulation can shorten them
`timescale 1ns/100ps
module osrc_dev #(
    parameter int unsigned POR_SYNC_CYC = osrc_pkg::POR_SYNC_CYC,
    parameter int unsigned POR_RUN_CYC  = osrc_pkg::POR_RUN_CYC,
    parameter int unsigned HRST_EE_CYC  = osrc_pkg::HRST_EE_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        ce_i,
    // Link to host
    osrc_link_if.dev         lk,
    // Calibration status
    input  wire logic        vco_cal_busy_i,
    // Clock outputs, half A and half B
    output logic [11:0]      out_a_o,
    output logic [11:0]      out_b_o,
    output logic [11:0]      out_a_oe_n_o,
    output logic [11:0]      out_b_oe_n_o
);
    localparam int CW = osrc_pkg::CW;

    logic [3:0]    s1_reg;
    logic [3:0]    s2_reg;
    logic [3:0]    s3_reg;
    logic [3:0]    pin_reg;
    logic [CW-1:0] por_cnt_reg;
    logic [CW-1:0] hw_cnt_reg;
    logic          srst_reg;
    logic [7:0]    spc_reg;
    logic [7:0]    sh_reg [osrc_pkg::IX_DRV:osrc_pkg::IX_ALN];
    logic [7:0]    act_reg [osrc_pkg::IX_DRV:osrc_pkg::IX_ALN];
    logic [3:0]    aln_cnt_reg;
    logic [7:0]    rdata_reg;
    logic [3:0]    div_clk;
    logic [4:0]    idx;
    logic          wr_hit;
    logic          upd;
    logic          restore;
    logic          por_quiet;
    logic          align_raw;
    logic          align_hold;
    logic          off;
    logic          ee;

    function automatic logic [4:0] reg_idx(input logic [11:0] a);
        if (a == osrc_pkg::A_SPC)
            return osrc_pkg::IX_SPC;
        if (a >= osrc_pkg::A_DRV0 && a <= osrc_pkg::A_DRVL)
            return 5'(a - osrc_pkg::A_DRV0) + osrc_pkg::IX_DRV;
        if (a >= osrc_pkg::A_DIV0 && a <= osrc_pkg::A_DIVL)
            return 5'(a - osrc_pkg::A_DIV0) + osrc_pkg::IX_DIV;
        if (a == osrc_pkg::A_ALN)
            return osrc_pkg::IX_ALN;
        return osrc_pkg::IX_NONE;
    endfunction

    function automatic logic [7:0] rst_val(input logic [4:0] i,
                                           input logic e);
        logic [4:0] k;
        k = i - osrc_pkg::IX_DIV;
        if (i < osrc_pkg::IX_DIV)
            return e ? osrc_pkg::DRV_EE : osrc_pkg::DRV_DEF;
        if (i == osrc_pkg::IX_ALN)
            return osrc_pkg::ALN_RST;
        if (k % 5'h03 == 5'h00)
            return e ? osrc_pkg::MN_EE : osrc_pkg::MN_DEF;
        if (k % 5'h03 == 5'h01)
            return e ? osrc_pkg::PH_EE : osrc_pkg::PH_DEF;
        return 8'h00;
    endfunction

    assign idx    = reg_idx(lk.sp_addr);
    assign wr_hit = lk.sp_wr && idx != osrc_pkg::IX_NONE
                    && idx != osrc_pkg::IX_SPC;
    assign upd    = lk.sp_wr && lk.sp_addr == osrc_pkg::A_UPD
                    && lk.sp_wdata[osrc_pkg::UPD_ALL];
    assign ee     = pin_reg[3];

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_reg  <= osrc_pkg::PIN_RST;
            s2_reg  <= osrc_pkg::PIN_RST;
            s3_reg  <= osrc_pkg::PIN_RST;
            pin_reg <= osrc_pkg::PIN_RST;
        end else if (ce_i) begin
            s1_reg <= {lk.cfg_src, lk.sleep_pin_n, lk.hrst_n, lk.sync_n};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int p = 0; p < 4; p++) begin
                if (s2_reg[p] == s3_reg[p])
                    pin_reg[p] <= s3_reg[p];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            por_cnt_reg <= '0;
        else if (ce_i && por_cnt_reg < CW'(POR_RUN_CYC))
            por_cnt_reg <= por_cnt_reg + CW'(1);
    end
    assign por_quiet = por_cnt_reg < CW'(POR_RUN_CYC);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            hw_cnt_reg <= '0;
        else if (ce_i) begin
            if (!pin_reg[1])
                hw_cnt_reg <= ee ? CW'(HRST_EE_CYC)
                                 : CW'(osrc_pkg::HRST_FAST_CYC);
            else if (hw_cnt_reg != '0)
                hw_cnt_reg <= hw_cnt_reg - CW'(1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            srst_reg <= 1'b0;
            spc_reg  <= osrc_pkg::SPC_RST;
        end else if (ce_i) begin
            if (lk.sp_wr && idx == osrc_pkg::IX_SPC) begin
                spc_reg <= lk.sp_wdata;
                if (lk.sp_wdata[osrc_pkg::SPC_SRST_A] ||
                    lk.sp_wdata[osrc_pkg::SPC_SRST_B]) begin
                    srst_reg                       <= 1'b1;
                    spc_reg[osrc_pkg::SPC_SRST_A] <= 1'b1;
                    spc_reg[osrc_pkg::SPC_SRST_B] <= 1'b1;
                end
            end else if (srst_reg && lk.sp_tick) begin
                srst_reg                       <= 1'b0;
                spc_reg[osrc_pkg::SPC_SRST_A] <= 1'b0;
                spc_reg[osrc_pkg::SPC_SRST_B] <= 1'b0;
            end
        end
    end

    assign restore = por_cnt_reg < CW'(osrc_pkg::POR_LOAD_CYC)
                     || !pin_reg[1] || srst_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = osrc_pkg::IX_DRV; i <= osrc_pkg::IX_ALN; i++) begin
                sh_reg[i]  <= rst_val(5'(i), 1'b0);
                act_reg[i] <= rst_val(5'(i), 1'b0);
            end
        end else if (ce_i) begin
            if (restore) begin
                for (int i = osrc_pkg::IX_DRV; i <= osrc_pkg::IX_ALN;
                     i++) begin
                    sh_reg[i]  <= rst_val(5'(i), ee);
                    act_reg[i] <= rst_val(5'(i), ee);
                end
            end else begin
                if (upd) begin
                    for (int i = osrc_pkg::IX_DRV; i <= osrc_pkg::IX_ALN;
                         i++)
                        act_reg[i] <= sh_reg[i];
                end
                if (wr_hit) begin
                    sh_reg[idx] <= lk.sp_wdata;
                    if (idx < osrc_pkg::IX_DIV
                        && lk.sp_wdata[osrc_pkg::DRV_CMOS]
                        && !sh_reg[idx][osrc_pkg::DRV_CMOS]) begin
                        sh_reg[idx][osrc_pkg::DRV_ENA] <= 1'b1;
                        sh_reg[idx][osrc_pkg::DRV_ENB] <= 1'b1;
                    end
                end
            end
        end
    end

    assign align_raw = !pin_reg[0] || !pin_reg[2] || !pin_reg[1]
                       || act_reg[osrc_pkg::IX_ALN][osrc_pkg::ALN_SOFT]
                       || act_reg[osrc_pkg::IX_ALN][osrc_pkg::ALN_DPD]
                       || srst_reg || hw_cnt_reg != '0 || vco_cal_busy_i
                       || por_cnt_reg < CW'(POR_SYNC_CYC);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            aln_cnt_reg <= osrc_pkg::ALIGN_PIPE_CYC;
        else if (ce_i) begin
            if (align_raw)
                aln_cnt_reg <= osrc_pkg::ALIGN_PIPE_CYC;
            else if (aln_cnt_reg != 4'h0)
                aln_cnt_reg <= aln_cnt_reg - 4'h1;
        end
    end
    assign align_hold = align_raw || aln_cnt_reg != 4'h0;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            rdata_reg <= 8'h00;
        else if (ce_i && lk.sp_rd) begin
            if (idx == osrc_pkg::IX_SPC)
                rdata_reg <= spc_reg;
            else if (idx != osrc_pkg::IX_NONE)
                rdata_reg <= sh_reg[idx];
            else if (lk.sp_addr == osrc_pkg::A_STAT)
                rdata_reg <= {5'h00, hw_cnt_reg != '0, srst_reg,
                              align_hold};
            else
                rdata_reg <= 8'h00;
        end
    end
    assign lk.sp_rdata = rdata_reg;

    for (genvar k = 0; k < 4; k++) begin : g_ch
        logic hold;
        assign hold = align_hold
            && !act_reg[osrc_pkg::IX_DIV + 5'(3 * k) + 5'h02]
                       [osrc_pkg::DIV_IGN];
        osrc_chdiv u_div (
            .ref_clk_i (ref_clk_i),
            .arst_n_i  (arst_n_i),
            .ce_i      (ce_i),
            .hold_i    (hold),
            .mn_i      (act_reg[osrc_pkg::IX_DIV + 5'(3 * k)]),
            .ph_i      (act_reg[osrc_pkg::IX_DIV + 5'(3 * k) + 5'h01]),
            .div_o     (div_clk[k])
        );
    end

    // Sleep and distribution power-down tristate every driver
    assign off = !pin_reg[2] || por_quiet
                 || act_reg[osrc_pkg::IX_ALN][osrc_pkg::ALN_DPD];

    for (genvar j = 0; j < 12; j++) begin : g_out
        logic [7:0] c;
        logic       on;
        logic       a;
        assign c  = act_reg[osrc_pkg::IX_DRV + 5'(j)];
        assign on = !off && !c[osrc_pkg::DRV_PD];
        assign a  = div_clk[j / 3] ^ c[osrc_pkg::DRV_INVA];
        always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                out_a_o[j]      <= 1'b0;
                out_b_o[j]      <= 1'b0;
                out_a_oe_n_o[j] <= 1'b1;
                out_b_oe_n_o[j] <= 1'b1;
            end else if (ce_i) begin
                out_a_o[j] <= a;
                out_b_o[j] <= c[osrc_pkg::DRV_CMOS]
                    ? div_clk[j / 3] ^ c[osrc_pkg::DRV_INVB] : !a;
                out_a_oe_n_o[j] <= !(on && (!c[osrc_pkg::DRV_CMOS]
                                     || c[osrc_pkg::DRV_ENA]));
                out_b_oe_n_o[j] <= !(on && (!c[osrc_pkg::DRV_CMOS]
                                     || c[osrc_pkg::DRV_ENB]));
            end
        end
    end
endmodule

// ===== osrc_pkg.sv
// Purpose: Shared map, field positions, reset images and timing counts
// Assumes: 200 MHz channel divider input clock
// Notes:   Reset images marked EEPROM stand for stored settings
package osrc_pkg;
    localparam int CLK_MHZ = 200;
    localparam int CW      = 24;
    // Register byte addresses
    localparam logic [11:0] A_SPC  = 12'h000;
    localparam logic [11:0] A_DRV0 = 12'h0f0;
    localparam logic [11:0] A_DRVL = 12'h0fb;
    localparam logic [11:0] A_DIV0 = 12'h190;
    localparam logic [11:0] A_DIVL = 12'h19b;
    localparam logic [11:0] A_ALN  = 12'h230;
    localparam logic [11:0] A_STAT = 12'h231;
    localparam logic [11:0] A_UPD  = 12'h232;
    // Storage indices
    localparam logic [4:0] IX_DRV  = 5'h01;
    localparam logic [4:0] IX_DIV  = 5'h0d;
    localparam logic [4:0] IX_ALN  = 5'h19;
    localparam logic [4:0] IX_SPC  = 5'h00;
    localparam logic [4:0] IX_NONE = 5'h1f;
    // Field positions
    localparam int SPC_SRST_A = 2;
    localparam int SPC_SRST_B = 5;
    localparam int ALN_SOFT   = 0;
    localparam int ALN_DPD    = 1;
    localparam int UPD_ALL    = 0;
    localparam int DRV_PD     = 0;
    localparam int DRV_INVA   = 1;
    localparam int DRV_INVB   = 2;
    localparam int DRV_CMOS   = 3;
    localparam int DRV_ENA    = 5;
    localparam int DRV_ENB    = 6;
    localparam int PH_SH      = 4;
    localparam int PH_PO_MSB  = 3;
    localparam int DIV_IGN    = 7;
    // Reset values, on-chip defaults and stored image
    localparam logic [7:0] SPC_RST = 8'h00;
    localparam logic [7:0] DRV_DEF = 8'h00;
    localparam logic [7:0] DRV_EE  = 8'h08;
    localparam logic [7:0] MN_DEF  = 8'h00;
    localparam logic [7:0] MN_EE   = 8'h11;
    localparam logic [7:0] PH_DEF  = 8'h00;
    localparam logic [7:0] PH_EE   = 8'h00;
    localparam logic [7:0] ALN_RST = 8'h00;
    localparam logic [3:0] PIN_RST = 4'h7;
    // Timing
    // Four sync stages plus this hold put outputs 16 cycles after the pin
    localparam logic [3:0] ALIGN_PIPE_CYC = 4'ha;
    localparam int POR_LOAD_CYC  = 8;
    localparam int HRST_FAST_NS  = 2000;
    localparam int HRST_FAST_CYC = HRST_FAST_NS * CLK_MHZ / 1000;
    localparam int HRST_EE_MS    = 20;
    localparam int HRST_EE_CYC   = HRST_EE_MS * CLK_MHZ * 1000;
    localparam int POR_SYNC_MS   = 50;
    localparam int POR_SYNC_CYC  = POR_SYNC_MS * CLK_MHZ * 1000;
    localparam int POR_RUN_MS    = 70;
    localparam int POR_RUN_CYC   = POR_RUN_MS * CLK_MHZ * 1000;
endpackage

// ===== osrc_link_if.sv
// Purpose: Pins and serial register access between host and device
// Assumes: Single clock shared by both ends
// Notes:   Active-low pins idle high
`timescale 1ns/100ps
interface osrc_link_if;
    logic        sync_n;
    logic        hrst_n;
    logic        sleep_pin_n;
    logic        cfg_src;
    logic [11:0] sp_addr;
    logic [7:0]  sp_wdata;
    logic        sp_wr;
    logic        sp_rd;
    logic [7:0]  sp_rdata;
    logic        sp_tick;
    modport dev (
        input  sync_n, hrst_n, sleep_pin_n, cfg_src,
        input  sp_addr, sp_wdata, sp_wr, sp_rd, sp_tick,
        output sp_rdata
    );
    modport host (
        output sync_n, hrst_n, sleep_pin_n, cfg_src,
        output sp_addr, sp_wdata, sp_wr, sp_rd, sp_tick,
        input  sp_rdata
    );
endinterface

// ===== osrc_chdiv.sv
// Purpose: One channel divider with static preset and phase delay
// Assumes: hold comes from the clock domain of ref_clk_i
// Notes:   Settings are latched only while held
`timescale 1ns/100ps
module osrc_chdiv (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       ce_i,
    // Control
    input  wire logic       hold_i,
    input  wire logic [7:0] mn_i,
    input  wire logic [7:0] ph_i,
    // Divided clock
    output logic            div_o
);
    typedef enum logic [2:0] {
        OSRC_DLY = 3'b001,
        OSRC_HI  = 3'b010,
        OSRC_LO  = 3'b100
    } osrc_dstate_t;

    osrc_dstate_t st_reg;
    logic [4:0]   cnt_reg;
    logic [3:0]   m_reg;
    logic [3:0]   n_reg;
    logic [4:0]   phi;
    logic [4:0]   dly;

    assign phi = {ph_i[osrc_pkg::PH_SH], ph_i[osrc_pkg::PH_PO_MSB:0]};
    assign dly = phi[4] ? 5'({1'b0, phi[3:0]} + {1'b0, mn_i[7:4]} + 5'h01)
                        : phi;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg  <= OSRC_DLY;
            cnt_reg <= 5'h00;
            m_reg   <= 4'h0;
            n_reg   <= 4'h0;
            div_o   <= 1'b0;
        end else if (ce_i) begin
            if (hold_i) begin
                st_reg  <= OSRC_DLY;
                cnt_reg <= dly;
                m_reg   <= mn_i[7:4];
                n_reg   <= mn_i[3:0];
                div_o   <= ph_i[osrc_pkg::PH_SH];
            end else if (cnt_reg != 5'h00) begin
                cnt_reg <= cnt_reg - 5'h01;
            end else begin
                case (st_reg)
                    OSRC_DLY, OSRC_LO: begin
                        st_reg  <= OSRC_HI;
                        cnt_reg <= {1'b0, n_reg};
                        div_o   <= 1'b1;
                    end
                    OSRC_HI: begin
                        st_reg  <= OSRC_LO;
                        cnt_reg <= {1'b0, m_reg};
                        div_o   <= 1'b0;
                    end
                    default: st_reg <= OSRC_DLY;
                endcase
            end
        end
    end
endmodule

// ===== osrc_host.sv
// Purpose: Host end driving pins and device registers
// Assumes: Device answers reads one cycle after the strobe
// Notes:   Update-all after an align write and the extra serial tick after a soft reset write are issued automatically
`timescale 1ns/100ps
module osrc_host (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        ce_i,
    // Command port
    input  wire logic [12:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [7:0]       rdata_o,
    // Link to device
    osrc_link_if.host        lk
);
    localparam logic [12:0] A_PINS = 13'h1000;
    localparam logic [12:0] A_HST  = 13'h1001;

    logic [3:0] pins_reg;
    logic       upd_reg;
    logic       tick_reg;
    logic       rd_dev_reg;
    logic [7:0] own_reg;
    logic       dev_wr;
    logic       inject;

    assign dev_wr = wr_i && !addr_i[12];
    assign inject = upd_reg && !wr_i && !rd_i;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            pins_reg <= 4'h0;
        else if (ce_i && wr_i && addr_i == A_PINS)
            pins_reg <= wdata_i[3:0];
    end
    assign lk.sync_n      = !pins_reg[0];
    assign lk.hrst_n      = !pins_reg[1];
    assign lk.sleep_pin_n = !pins_reg[2];
    assign lk.cfg_src     = pins_reg[3];

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            upd_reg <= 1'b0;
        else if (ce_i) begin
            if (dev_wr && addr_i[11:0] == osrc_pkg::A_ALN)
                upd_reg <= 1'b1;
            else if (inject)
                upd_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            tick_reg <= 1'b0;
        else if (ce_i)
            tick_reg <= dev_wr && addr_i[11:0] == osrc_pkg::A_SPC
                        && (wdata_i[osrc_pkg::SPC_SRST_A]
                            || wdata_i[osrc_pkg::SPC_SRST_B]);
    end
    assign lk.sp_tick = tick_reg && ce_i;

    assign lk.sp_addr  = inject ? osrc_pkg::A_UPD : addr_i[11:0];
    assign lk.sp_wdata = inject ? 8'h01 : wdata_i;
    assign lk.sp_wr    = ce_i && (dev_wr || inject);
    assign lk.sp_rd    = ce_i && rd_i && !addr_i[12];

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_dev_reg <= 1'b0;
            own_reg    <= 8'h00;
        end else if (ce_i) begin
            rd_dev_reg <= rd_i && !addr_i[12];
            if (rd_i && addr_i == A_PINS)
                own_reg <= {4'h0, pins_reg};
            else if (rd_i && addr_i == A_HST)
                own_reg <= {6'h00, tick_reg, upd_reg};
            else
                own_reg <= 8'h00;
        end
    end
    assign rdata_o = rd_dev_reg ? lk.sp_rdata : own_reg;
endmodule

// ===== osrc_assertions.sv
// Purpose: Link checks between host end and device end
// Assumes: One clock, asynchronous active-low reset
// Notes:   Sees only link signals, so device pins are judged by the bench
`timescale 1ns/100ps
module osrc_assertions (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // Pins
    input  wire logic        sync_n,
    input  wire logic        hrst_n,
    input  wire logic        sleep_pin_n,
    // Register access
    input  wire logic [11:0] sp_addr,
    input  wire logic [7:0]  sp_wdata,
    input  wire logic        sp_wr,
    input  wire logic        sp_rd,
    input  wire logic [7:0]  sp_rdata,
    input  wire logic        sp_tick
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_upd_after_aln;
        sp_wr && sp_addr == osrc_pkg::A_ALN |-> ##[1:4]
            (sp_wr && sp_addr == osrc_pkg::A_UPD && sp_wdata[0]);
    endproperty
    a_upd_after_aln: assert property (p_upd_after_aln)
        else $error("no update write after align write");
    property p_upd_data;
        sp_wr && sp_addr == osrc_pkg::A_UPD |-> sp_wdata == 8'h01;
    endproperty
    a_upd_data: assert property (p_upd_data)
        else $error("update write carries wrong data");
    property p_upd_single;
        sp_wr && sp_addr == osrc_pkg::A_UPD
            |=> !(sp_wr && sp_addr == osrc_pkg::A_UPD);
    endproperty
    a_upd_single: assert property (p_upd_single)
        else $error("update write repeated");
    property p_upd_reads_zero;
        sp_rd && sp_addr == osrc_pkg::A_UPD |=> sp_rdata == 8'h00;
    endproperty
    a_upd_reads_zero: assert property (p_upd_reads_zero)
        else $error("update register read not zero");
    property p_tick_after_srst;
        sp_wr && sp_addr == osrc_pkg::A_SPC && (sp_wdata[2] || sp_wdata[5])
            |=> sp_tick;
    endproperty
    a_tick_after_srst: assert property (p_tick_after_srst)
        else $error("no serial tick after soft reset write");
    property p_tick_pulse;
        sp_tick |=> !sp_tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("serial tick longer than one cycle");
    property p_srst_cleared;
        sp_tick && !sp_wr ##[1:8] (sp_rd && sp_addr == osrc_pkg::A_SPC)
            |=> !sp_rdata[2] && !sp_rdata[5];
    endproperty
    a_srst_cleared: assert property (p_srst_cleared)
        else $error("soft reset bits not self-cleared");
    property p_pins_idle;
        $rose(arst_n_i) |-> sync_n && hrst_n && sleep_pin_n;
    endproperty
    a_pins_idle: assert property (p_pins_idle)
        else $error("pins not released after reset");
endmodule

// ===== output_sync_and_reset_control_tb.sv
// Purpose: Bench for host and device ends joined by the link
// Assumes: Power-on and reset waits shortened by parameters
// Notes:   Phase step is measured against an unshifted run
`timescale 1ns/100ps
module output_sync_and_reset_control_tb;
    logic        ref_clk;
    logic        arst_n;
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        vco;
    logic [7:0]  rdata;
    logic [11:0] oa, ob, oea, oeb;
    int          miscompares;
    int          n_compared;
    osrc_link_if lk ();
    osrc_host osrc_host_inst (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
        .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .lk(lk.host));
    osrc_dev #(.POR_SYNC_CYC(200), .POR_RUN_CYC(300), .HRST_EE_CYC(100))
        osrc_dev_inst (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .ce_i(1'b1),
        .lk(lk.dev), .vco_cal_busy_i(vco), .out_a_o(oa), .out_b_o(ob),
        .out_a_oe_n_o(oea), .out_b_oe_n_o(oeb));
    osrc_assertions osrc_assertions_inst (.ref_clk_i(ref_clk),
        .arst_n_i(arst_n), .sync_n(lk.sync_n), .hrst_n(lk.hrst_n),
        .sleep_pin_n(lk.sleep_pin_n), .sp_addr(lk.sp_addr),
        .sp_wdata(lk.sp_wdata), .sp_wr(lk.sp_wr), .sp_rd(lk.sp_rd),
        .sp_rdata(lk.sp_rdata), .sp_tick(lk.sp_tick));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Idle cycles after the write leave room for injected update and tick
    task automatic wr_reg(input logic [12:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk("register", e, rdata);
    endtask
    // Sampled between edges so the count sees settled outputs
    task automatic rise(output int n);
        n = 0;
        while (oa[0] !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
    endtask
    task automatic t_regs;
        rd_chk(13'h0f0, osrc_pkg::DRV_DEF);
        rd_chk(13'h232, 8'h00);
        rd_chk(13'h3ff, 8'h00);
        chk("differential", 8'h01, {7'h0, oa[0] ^ ob[0]});
        chk("por drives", 8'h00, {7'h0, oea[0]});
    endtask
    task automatic t_soft;
        wr_reg(13'h0f0, 8'h01);
        wr_reg(13'h000, 8'h21);
        rd_chk(13'h000, 8'h01);
        rd_chk(13'h0f0, osrc_pkg::DRV_DEF);
        wr_reg(13'h1000, 8'h08);
        wr_reg(13'h000, 8'h04);
        rd_chk(13'h0f0, osrc_pkg::DRV_EE);
        wr_reg(13'h1000, 8'h00);
        wr_reg(13'h000, 8'h04);
        rd_chk(13'h0f0, osrc_pkg::DRV_DEF);
        repeat (40) @(posedge ref_clk);
    endtask
    task automatic t_cmos;
        wr_reg(13'h0f0, 8'h08);
        rd_chk(13'h0f0, 8'h68);
        wr_reg(13'h0f0, 8'h28);
        wr_reg(13'h232, 8'h01);
        chk("half enables", 8'h01, {6'h0, oea[0], oeb[0]});
        wr_reg(13'h0f0, 8'h00);
        wr_reg(13'h232, 8'h01);
    endtask
    task automatic t_sync;
        int n[2];
        for (int k = 0; k < 2; k++) begin
            wr_reg(13'h191, (k == 0) ? 8'h00 : 8'h03);
            wr_reg(13'h232, 8'h01);
            wr_reg(13'h1000, 8'h01);
            repeat (20) @(posedge ref_clk);
            chk("held", 8'h00, {7'h0, oa[0]});
            wr_reg(13'h1000, 8'h00);
            rise(n[k]);
        end
        // Pin rose three edges before the count starts, and the count includes the edge after the rise
        chk("latency", 8'h01, {7'h0, n[0] + 2 >= 15 && n[0] + 2 <= 16});
        chk("phase step", 8'h03, 8'(n[1] - n[0]));
    endtask
    task automatic t_events;
        int n;
        vco <= 1'b1;
        repeat (30) @(posedge ref_clk);
        chk("cal held", 8'h00, {7'h0, oa[0]});
        vco <= 1'b0;
        rise(n);
        chk("cal resumes", 8'h01, {7'h0, n < 60});
        wr_reg(13'h230, 8'h01);
        repeat (30) @(posedge ref_clk);
        chk("soft held", 8'h00, {7'h0, oa[0]});
        wr_reg(13'h230, 8'h00);
        rise(n);
        chk("soft resumes", 8'h01, {7'h0, n < 60});
        wr_reg(13'h0f0, 8'h01);
        wr_reg(13'h1000, 8'h02);
        wr_reg(13'h1000, 8'h00);
        repeat (395) @(posedge ref_clk);
        chk("hard held", 8'h00, {7'h0, oa[0]});
        rise(n);
        chk("hard resumes", 8'h01, {7'h0, n < 60});
        rd_chk(13'h0f0, osrc_pkg::DRV_DEF);
    endtask
    task automatic t_more;
        logic p;
        int   n;
        wr_reg(13'h192, 8'h80);
        wr_reg(13'h232, 8'h01);
        wr_reg(13'h1000, 8'h01);
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk) p = oa[0];
        @(negedge ref_clk);
        chk("excluded runs", 8'h01, {7'h0, oa[0] ^ p});
        chk("included held", 8'h00, {7'h0, oa[3]});
        wr_reg(13'h192, 8'h00);
        wr_reg(13'h232, 8'h01);
        wr_reg(13'h1000, 8'h04);
        repeat (20) @(posedge ref_clk);
        chk("sleep held", 8'h00, {7'h0, oa[0]});
        chk("sleep off", 8'h01, {7'h0, &{oea, oeb}});
        wr_reg(13'h1000, 8'h00);
        rise(n);
        chk("sleep resumes", 8'h01, {7'h0, n < 60});
        wr_reg(13'h0f0, 8'h02);
        wr_reg(13'h232, 8'h01);
        @(negedge ref_clk);
        chk("inverted", 8'h01, {7'h0, oa[0] ^ oa[1]});
        @(posedge ref_clk);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        addr   = '0;
        wdata  = '0;
        wr     = 1'b0;
        rd     = 1'b0;
        vco    = 1'b0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (250) @(posedge ref_clk);
        chk("por quiet", 8'h01, {7'h0, &oea});
        repeat (70) @(posedge ref_clk);
        t_regs;
        t_soft;
        t_cmos;
        t_sync;
        t_events;
        t_more;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        report_and_stop;
    end
endmodule
